/* rtl/rcs_pkg.sv */
// Constants and types for the radio channel sense and tuning block
package rcs_pkg;
	// Symbol period and averaging window
	localparam int SYMBOL_NS = 16000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SYMBOL_CYCLES = SYMBOL_NS / CLK_PERIOD_NS;
	localparam int AVG_SYMBOLS = 8;
	localparam int AVG_SHIFT = 3;
	localparam int CORR_SYMBOLS = 8;
	localparam int VALID_SYMBOLS = 8;
	// Frequency plan in MHz
	localparam int SYNTH_CHANNEL_WORD_BASE_MHZ = 2048;
	localparam int IF_MHZ = 2;
	localparam logic [9:0] SYNTH_CHANNEL_WORD_RESET = 10'h165;
	localparam logic [11:0] LO_BASE = 12'h800;
	localparam logic [11:0] IF_OFFSET = 12'h002;
	// Transmit power reset code
	localparam logic [7:0] TX_POWER_RESET = 8'hff;
	// Clear channel criterion codes
	localparam logic [1:0] CCA_RESERVED = 2'h0;
	localparam logic [1:0] CCA_ENERGY = 2'h1;
	localparam logic [1:0] CCA_CARRIER = 2'h2;
	localparam logic [1:0] CCA_BOTH = 2'h3;
	localparam logic [1:0] CLEAR_CHANNEL_CRITERION_RESET = 2'h3;
	localparam logic signed [7:0] THR_RESET = 8'shc0;
	localparam logic [2:0] HYST_RESET = 3'h2;
	// Calibration length in cycles
	localparam int CAL_CYCLES = 48;
	// Radio control states
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_RX_CAL = 5'h02,
		ST_RX = 5'h04,
		ST_TX_CAL = 5'h08,
		ST_TX = 5'h10
	} rcs_state_t;
endpackage

/* rtl/rcs_avg.sv */
// Eight symbol running average of signal strength samples
`timescale 1ns/1ps
module rcs_avg #(
	parameter int SYM_CYCLES = rcs_pkg::SYMBOL_CYCLES
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sample in
	input wire logic run,
	input wire logic signed [7:0] sample,
	// Average out
	output logic signed [7:0] average,
	output logic sym_tick
);
	import rcs_pkg::*;

	// ****************************************
	// Symbol timing and accumulation
	// ****************************************
	logic [15:0] cyc; // Cycles into current symbol
	logic signed [7:0] hist [0:AVG_SYMBOLS-1]; // One sample per symbol
	logic signed [10:0] sum; // Sum of window
	wire tick = run && (cyc == 16'(SYM_CYCLES - 1));
	wire signed [10:0] next_sum = sum + 11'(sample) - 11'(hist[AVG_SYMBOLS-1]);

	assign sym_tick = tick;

	// Sample one value per symbol, keep eight symbol window
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cyc <= 16'h0000;
			sum <= 11'sh000;
			average <= 8'sh00;
			for (int i = 0; i < AVG_SYMBOLS; i++)
				hist[i] <= 8'sh00;
		end
		else if (!run)
			cyc <= 16'h0000; // Symbol timing restarts when receiver turns on again; window history and sum are kept
		else
		begin
			cyc <= tick ? 16'h0000 : cyc + 16'h0001;
			if (tick)
			begin
				hist[0] <= sample;
				for (int i = 1; i < AVG_SYMBOLS; i++)
					hist[i] <= hist[i-1];
				sum <= next_sum;
				average <= 8'(next_sum >>> AVG_SHIFT);
			end
		end
	end
endmodule

/* rtl/rcs_top.sv */
// Channel sense, correlation report, clear channel and synthesizer control
`timescale 1ns/1ps
module rcs_top #(
	parameter int SYM_CYCLES = rcs_pkg::SYMBOL_CYCLES,
	parameter int CAL_LEN = rcs_pkg::CAL_CYCLES
)(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Receiver front end samples
	input wire logic signed [7:0] RAW_STRENGTH,
	input wire logic [6:0] SYMBOL_CORR,
	input wire logic SYMBOL_STROBE,
	input wire logic SFD_DETECT,
	input wire logic FRAME_END,
	input wire logic CRC_OK,
	input wire logic VALID_RECEPTION,
	// Software control
	input wire logic RX_ENABLE_STROBE,
	input wire logic TX_ENABLE_STROBE,
	input wire logic TRANSMIT_IF_CLEAR_STROBE,
	input wire logic RADIO_OFF_STROBE,
	input wire logic TX_DONE,
	input wire logic AUTO_CHECK_APPEND,
	input wire logic signed [7:0] CARRIER_SENSE_THRESHOLD,
	input wire logic [2:0] CARRIER_SENSE_HYSTERESIS,
	input wire logic [1:0] CLEAR_CHANNEL_CRITERION,
	input wire logic [1:0] SYNTH_CONTROL_HIGH,
	input wire logic [7:0] SYNTH_CONTROL_LOW,
	input wire logic [7:0] TRANSMIT_POWER_REGISTER,
	input wire logic CLEAR_CHANNEL_IRQ_CLEAR,
	// Status to software
	output logic signed [7:0] SIGNAL_STRENGTH_READING,
	output logic CLEAR_CHANNEL,
	output logic CLEAR_CHANNEL_VALID,
	output logic CLEAR_CHANNEL_IRQ_FLAG,
	output logic TX_ACTIVE,
	output logic [4:0] RADIO_STATE,
	// Frame trailer append
	output logic APPEND_VALID,
	output logic signed [7:0] APPEND_STRENGTH,
	output logic [7:0] APPEND_CORR_CRC,
	// Synthesizer
	output logic [11:0] LO_SYNTH_CHANNEL_WORD_MHZ,
	output logic [11:0] CARRIER_MHZ,
	output logic SYNTH_CALIBRATE,
	output logic [7:0] PA_POWER_CODE
);
	import rcs_pkg::*;

	// ****************************************
	// Input synchronisers (front end is asynchronous)
	// ****************************************
	logic [4:0] sync1; // First stage, read only by second
	logic [4:0] sync2; // Safe copies
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end
		else
		begin
			sync1 <= {SYMBOL_STROBE, SFD_DETECT, FRAME_END, CRC_OK, VALID_RECEPTION};
			sync2 <= sync1;
		end
	end
	wire sym_s = sync2[4];
	wire sfd_s = sync2[3];
	wire end_s = sync2[2];
	wire crc_s = sync2[1];
	wire valid_rx_s = sync2[0];
	logic sym_d, sfd_d, end_d; // Edge history
	wire sym_rise = sym_s && !sym_d;
	wire sfd_rise = sfd_s && !sfd_d;
	wire end_rise = end_s && !end_d;

	// Sample buses are quasi static; two stages keep them settled
	logic signed [7:0] raw1, raw2;
	logic [6:0] corr1, corr2;

	// ****************************************
	// Radio control state machine
	// ****************************************
	rcs_state_t state, next_state;
	logic [7:0] cal_cnt; // Calibration time left
	wire cal_done = (cal_cnt == 8'h00);
	wire rx_on = (state == ST_RX);

	// Strength averaging
	logic signed [7:0] avg;
	logic avg_tick;
	rcs_avg #(.SYM_CYCLES(SYM_CYCLES)) u_avg
	(
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.run(rx_on),
		.sample(raw2),
		.average(avg),
		.sym_tick(avg_tick)
	);

	// ****************************************
	// Clear channel evaluation
	// ****************************************
	logic [3:0] rx_syms; // Symbols since receiver enabled
	logic energy_low; // Hysteretic energy criterion
	wire signed [8:0] thr_hi = 9'(CARRIER_SENSE_THRESHOLD) + 9'(CARRIER_SENSE_HYSTERESIS);
	wire signed [8:0] thr_lo = 9'(CARRIER_SENSE_THRESHOLD) - 9'(CARRIER_SENSE_HYSTERESIS);
	wire above = 9'(avg) > thr_hi;
	wire below = 9'(avg) < thr_lo;
	wire cca_valid = rx_on && (rx_syms >= 4'(VALID_SYMBOLS));
	logic crit;
	always_comb
	begin
		case (CLEAR_CHANNEL_CRITERION)
			CCA_ENERGY: crit = energy_low;
			CCA_CARRIER: crit = !valid_rx_s;
			CCA_BOTH: crit = energy_low && !valid_rx_s;
			default: crit = 1'b0; // Reserved code never reports clear
		endcase
	end
	wire clear_now = cca_valid && crit;

	// Transmit-if-clear only leaves receive when channel is clear
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (TX_ENABLE_STROBE) next_state = ST_TX_CAL;
				else if (RX_ENABLE_STROBE) next_state = ST_RX_CAL;
			ST_RX_CAL:
				if (cal_done) next_state = ST_RX;
			ST_RX:
				if (TX_ENABLE_STROBE || (TRANSMIT_IF_CLEAR_STROBE && clear_now))
					next_state = ST_TX_CAL;
			ST_TX_CAL:
				if (cal_done) next_state = ST_TX;
			ST_TX:
				if (TX_DONE) next_state = ST_RX_CAL;
			default: next_state = ST_IDLE;
		endcase
		if (RADIO_OFF_STROBE)
			next_state = ST_IDLE;
	end
	wire entering_cal = (next_state == ST_RX_CAL || next_state == ST_TX_CAL) &&
		(next_state != state);

	// State, calibration counter, symbol count and energy latch
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state <= ST_IDLE;
			cal_cnt <= 8'h00;
			rx_syms <= 4'h0;
			energy_low <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (entering_cal)
				cal_cnt <= 8'(CAL_LEN - 1);
			else if (!cal_done)
				cal_cnt <= cal_cnt - 8'h01;
			if (!rx_on)
				rx_syms <= 4'h0;
			else if (avg_tick && rx_syms != 4'hf)
				rx_syms <= rx_syms + 4'h1;
			if (!cca_valid)
				energy_low <= 1'b0;
			else if (below)
				energy_low <= 1'b1;
			else if (above)
				energy_low <= 1'b0;
		end
	end

	// ****************************************
	// Per-frame correlation average
	// ****************************************
	logic [9:0] corr_sum; // Sum of eight 7-bit values
	logic [3:0] corr_n; // Symbols collected
	logic [6:0] corr_avg;
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sym_d <= 1'b0;
			sfd_d <= 1'b0;
			end_d <= 1'b0;
			raw1 <= 8'sh00;
			raw2 <= 8'sh00;
			corr1 <= 7'h00;
			corr2 <= 7'h00;
			corr_sum <= 10'h000;
			corr_n <= 4'h8;
			corr_avg <= 7'h00;
		end
		else
		begin
			sym_d <= sym_s;
			sfd_d <= sfd_s;
			end_d <= end_s;
			raw1 <= RAW_STRENGTH;
			raw2 <= raw1;
			corr1 <= SYMBOL_CORR;
			corr2 <= corr1;
			if (sfd_rise)
			begin
				corr_sum <= 10'h000;
				corr_n <= 4'h0;
			end
			else if (sym_rise && corr_n < 4'(CORR_SYMBOLS))
			begin
				corr_sum <= corr_sum + 10'(corr2);
				corr_n <= corr_n + 4'h1;
				if (corr_n == 4'(CORR_SYMBOLS - 1))
					corr_avg <= 7'((corr_sum + 10'(corr2)) >> 3);
			end
		end
	end

	// ****************************************
	// Status, append and synthesizer outputs
	// ****************************************
	wire [11:0] carrier = LO_BASE + {2'h0, SYNTH_CONTROL_HIGH, SYNTH_CONTROL_LOW};
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SIGNAL_STRENGTH_READING <= 8'sh00;
			CLEAR_CHANNEL <= 1'b0;
			CLEAR_CHANNEL_VALID <= 1'b0;
			CLEAR_CHANNEL_IRQ_FLAG <= 1'b0;
			TX_ACTIVE <= 1'b0;
			RADIO_STATE <= ST_IDLE;
			APPEND_VALID <= 1'b0;
			APPEND_STRENGTH <= 8'sh00;
			APPEND_CORR_CRC <= 8'h00;
			LO_SYNTH_CHANNEL_WORD_MHZ <= 12'h000;
			CARRIER_MHZ <= 12'h000;
			SYNTH_CALIBRATE <= 1'b0;
			PA_POWER_CODE <= TX_POWER_RESET;
		end
		else
		begin
			SIGNAL_STRENGTH_READING <= avg;
			CLEAR_CHANNEL <= clear_now;
			CLEAR_CHANNEL_VALID <= cca_valid;
			// Set wins over a simultaneous clear
			if (clear_now)
				CLEAR_CHANNEL_IRQ_FLAG <= 1'b1;
			else if (CLEAR_CHANNEL_IRQ_CLEAR)
				CLEAR_CHANNEL_IRQ_FLAG <= 1'b0;
			TX_ACTIVE <= (next_state == ST_TX_CAL) || (next_state == ST_TX);
			RADIO_STATE <= next_state;
			APPEND_VALID <= end_rise && AUTO_CHECK_APPEND;
			if (end_rise && AUTO_CHECK_APPEND)
			begin
				APPEND_STRENGTH <= avg;
				APPEND_CORR_CRC <= {crc_s, corr_avg};
			end
			CARRIER_MHZ <= carrier;
			LO_SYNTH_CHANNEL_WORD_MHZ <= rx_on || state == ST_RX_CAL ? carrier - IF_OFFSET : carrier;
			SYNTH_CALIBRATE <= (state == ST_RX_CAL) || (state == ST_TX_CAL);
			PA_POWER_CODE <= TRANSMIT_POWER_REGISTER;
		end
	end
endmodule

/* bench/rcs_top_assertions.sv */
// Concurrent checks on the ports of the channel sense block
`timescale 1ns/1ps
module rcs_chk #(
	parameter int SYM_CYCLES = 4,
	parameter int CAL_LEN = 8
)(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Watched inputs
	input wire logic TRANSMIT_IF_CLEAR_STROBE,
	input wire logic RADIO_OFF_STROBE,
	input wire logic TX_ENABLE_STROBE,
	input wire logic [1:0] CLEAR_CHANNEL_CRITERION,
	input wire logic [1:0] SYNTH_CONTROL_HIGH,
	input wire logic [7:0] SYNTH_CONTROL_LOW,
	input wire logic [7:0] TRANSMIT_POWER_REGISTER,
	// Watched outputs
	input wire logic CLEAR_CHANNEL,
	input wire logic CLEAR_CHANNEL_IRQ_FLAG,
	input wire logic TX_ACTIVE,
	input wire logic [4:0] RADIO_STATE,
	input wire logic APPEND_VALID,
	input wire logic [11:0] LO_SYNTH_CHANNEL_WORD_MHZ,
	input wire logic [11:0] CARRIER_MHZ,
	input wire logic SYNTH_CALIBRATE,
	input wire logic [7:0] PA_POWER_CODE
);
	// ****
	// One clock domain, one reset
	// ****
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Release edge excluded: outputs still hold reset values one cycle on
	a_carrier_word: assert property (RST_N |=> CARRIER_MHZ ==
		12'h800 + $past({SYNTH_CONTROL_HIGH, SYNTH_CONTROL_LOW})) else $error("carrier word");
	// Stable state so a pending state change cannot excuse a lag
	a_rx_lo_offset: assert property (RADIO_STATE == 5'h04 && $stable(RADIO_STATE) &&
		$stable(CARRIER_MHZ) |-> LO_SYNTH_CHANNEL_WORD_MHZ == CARRIER_MHZ - 12'h002) else $error("rx lo");
	a_tx_lo_equal: assert property (RADIO_STATE == 5'h10 && $stable(RADIO_STATE) &&
		$stable(CARRIER_MHZ) |-> LO_SYNTH_CHANNEL_WORD_MHZ == CARRIER_MHZ) else $error("tx lo");
	a_cal_starts: assert property ($rose(RADIO_STATE[1] | RADIO_STATE[3])
		|=> SYNTH_CALIBRATE) else $error("no calibration");
	a_cal_ends: assert property (RADIO_STATE == 5'h02 |-> ##[1:300] RADIO_STATE != 5'h02)
		else $error("calibration stuck");
	a_tx_on_clear: assert property (TRANSMIT_IF_CLEAR_STROBE && CLEAR_CHANNEL &&
		RADIO_STATE == 5'h04 && !RADIO_OFF_STROBE |=> TX_ACTIVE) else $error("tx not started");
	a_tx_refused: assert property (TRANSMIT_IF_CLEAR_STROBE && !CLEAR_CHANNEL && !TX_ACTIVE &&
		!TX_ENABLE_STROBE |=> !TX_ACTIVE) else $error("tx started busy");
	a_irq_follows: assert property ($rose(CLEAR_CHANNEL) |-> ##[0:2] CLEAR_CHANNEL_IRQ_FLAG)
		else $error("irq flag missing");
	a_append_pulse: assert property (APPEND_VALID |=> !APPEND_VALID) else $error("append long");
	a_reserved_mode: assert property ((CLEAR_CHANNEL_CRITERION == 2'h0) [*3]
		|-> !CLEAR_CHANNEL) else $error("reserved clear");
	a_power_pass: assert property (RST_N |=> PA_POWER_CODE == $past(TRANSMIT_POWER_REGISTER))
		else $error("power code");
endmodule
bind rcs_top rcs_chk #(.SYM_CYCLES(SYM_CYCLES), .CAL_LEN(CAL_LEN)) u_chk (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .TRANSMIT_IF_CLEAR_STROBE(TRANSMIT_IF_CLEAR_STROBE),
	.RADIO_OFF_STROBE(RADIO_OFF_STROBE), .TX_ENABLE_STROBE(TX_ENABLE_STROBE),
	.CLEAR_CHANNEL_CRITERION(CLEAR_CHANNEL_CRITERION), .SYNTH_CONTROL_HIGH(SYNTH_CONTROL_HIGH),
	.SYNTH_CONTROL_LOW(SYNTH_CONTROL_LOW), .TRANSMIT_POWER_REGISTER(TRANSMIT_POWER_REGISTER),
	.CLEAR_CHANNEL(CLEAR_CHANNEL), .CLEAR_CHANNEL_IRQ_FLAG(CLEAR_CHANNEL_IRQ_FLAG),
	.TX_ACTIVE(TX_ACTIVE), .RADIO_STATE(RADIO_STATE), .APPEND_VALID(APPEND_VALID),
	.LO_SYNTH_CHANNEL_WORD_MHZ(LO_SYNTH_CHANNEL_WORD_MHZ), .CARRIER_MHZ(CARRIER_MHZ), .SYNTH_CALIBRATE(SYNTH_CALIBRATE),
	.PA_POWER_CODE(PA_POWER_CODE));

/* bench/tb_top.sv */
// Self-checking bench for the channel sense and tuning block
`timescale 1ns/1ps
module tb_top;
	// ****
	// Stimulus and observed signals
	// ****
	logic CLK_SYS = 1'b0, RST_N = 1'b0, SYMBOL_STROBE = 1'b0, CRC_OK = 1'b1;
	logic VALID_RECEPTION = 1'b0, AUTO_CHECK_APPEND = 1'b1;
	logic signed [7:0] RAW_STRENGTH = 8'hd8, CARRIER_SENSE_THRESHOLD = 8'h00;
	logic [6:0] SYMBOL_CORR = 7'h50;
	logic [2:0] CARRIER_SENSE_HYSTERESIS = 3'h2;
	logic [1:0] CLEAR_CHANNEL_CRITERION = 2'h1, SYNTH_CONTROL_HIGH = 2'h1;
	logic [7:0] SYNTH_CONTROL_LOW = 8'h65, TRANSMIT_POWER_REGISTER = 8'hff;
	logic [7:0] stb = 8'h00; // One bit per strobe or edge input
	logic signed [7:0] SIGNAL_STRENGTH_READING, APPEND_STRENGTH;
	logic CLEAR_CHANNEL, CLEAR_CHANNEL_VALID, CLEAR_CHANNEL_IRQ_FLAG, TX_ACTIVE;
	logic APPEND_VALID, SYNTH_CALIBRATE;
	logic [4:0] RADIO_STATE;
	logic [7:0] APPEND_CORR_CRC, PA_POWER_CODE;
	logic [11:0] LO_SYNTH_CHANNEL_WORD_MHZ, CARRIER_MHZ;
	int bad_count = 0, tests_run = 0, cyc = 0, k;
	// Criterion, threshold, valid rx, expected clear; strength sits at -40
	localparam logic [11:0] CCA_TAB [8] = '{12'h000, 12'h802, 12'h801, 12'hf40,
		12'hf5c, 12'hf6d, 12'hf5d, 12'hf6e};
	// Short symbol and calibration keep the run brief
	rcs_top #(.SYM_CYCLES(4), .CAL_LEN(8)) u_dut
	(
		.CLK_SYS(CLK_SYS), .RST_N(RST_N), .RAW_STRENGTH(RAW_STRENGTH),
		.SYMBOL_CORR(SYMBOL_CORR), .SYMBOL_STROBE(SYMBOL_STROBE), .SFD_DETECT(stb[6]),
		.FRAME_END(stb[7]), .CRC_OK(CRC_OK), .VALID_RECEPTION(VALID_RECEPTION),
		.RX_ENABLE_STROBE(stb[0]), .TX_ENABLE_STROBE(stb[1]),
		.TRANSMIT_IF_CLEAR_STROBE(stb[2]), .RADIO_OFF_STROBE(stb[3]), .TX_DONE(stb[4]),
		.AUTO_CHECK_APPEND(AUTO_CHECK_APPEND),
		.CARRIER_SENSE_THRESHOLD(CARRIER_SENSE_THRESHOLD),
		.CARRIER_SENSE_HYSTERESIS(CARRIER_SENSE_HYSTERESIS),
		.CLEAR_CHANNEL_CRITERION(CLEAR_CHANNEL_CRITERION),
		.SYNTH_CONTROL_HIGH(SYNTH_CONTROL_HIGH), .SYNTH_CONTROL_LOW(SYNTH_CONTROL_LOW),
		.TRANSMIT_POWER_REGISTER(TRANSMIT_POWER_REGISTER),
		.CLEAR_CHANNEL_IRQ_CLEAR(stb[5]),
		.SIGNAL_STRENGTH_READING(SIGNAL_STRENGTH_READING), .CLEAR_CHANNEL(CLEAR_CHANNEL),
		.CLEAR_CHANNEL_VALID(CLEAR_CHANNEL_VALID),
		.CLEAR_CHANNEL_IRQ_FLAG(CLEAR_CHANNEL_IRQ_FLAG), .TX_ACTIVE(TX_ACTIVE),
		.RADIO_STATE(RADIO_STATE), .APPEND_VALID(APPEND_VALID),
		.APPEND_STRENGTH(APPEND_STRENGTH), .APPEND_CORR_CRC(APPEND_CORR_CRC),
		.LO_SYNTH_CHANNEL_WORD_MHZ(LO_SYNTH_CHANNEL_WORD_MHZ), .CARRIER_MHZ(CARRIER_MHZ),
		.SYNTH_CALIBRATE(SYNTH_CALIBRATE), .PA_POWER_CODE(PA_POWER_CODE)
	);
	// ****
	// Clock, symbol marker and hang guard
	// ****
	initial forever #2 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS)
	begin
		cyc <= cyc + 1;
		SYMBOL_STROBE <= cyc[1];
		if (cyc == 2000)
		begin
			bad_count++;
			end_of_test;
		end
	end
	// ****
	// Shared helpers
	// ****
	task chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	// One-cycle strobe; outputs looked at once the taking edge lands
	task pulse(input int i);
		@(posedge CLK_SYS);
		stb[i] <= 1'b1;
		@(posedge CLK_SYS);
		stb <= 8'h00;
		#1;
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	// Every standard channel, checked against the channel formula
	task t_synth_channel_word;
		for (k = 11; k <= 26; k++)
		begin
			@(posedge CLK_SYS);
			{SYNTH_CONTROL_HIGH, SYNTH_CONTROL_LOW} <= 10'(357 + 5 * (k - 11));
			TRANSMIT_POWER_REGISTER <= 8'h5f;
			wt(2);
			chk(CARRIER_MHZ, 12'(2405 + 5 * (k - 11)));
		end
		chk(PA_POWER_CODE, 8'h5f);
	endtask
	// Receive enable, calibration, averaging and first clear verdict
	task t_rx;
		pulse(0);
		chk(RADIO_STATE, 5'h02);
		wt(1);
		chk(SYNTH_CALIBRATE, 1'b1);
		repeat (40) if (RADIO_STATE !== 5'h04) wt(1);
		chk(RADIO_STATE, 5'h04);
		chk(LO_SYNTH_CHANNEL_WORD_MHZ, 12'h9ae);
		wt(60);
		chk({4'h0, SIGNAL_STRENGTH_READING}, 12'h0d8);
		chk(CLEAR_CHANNEL_VALID, 1'b1);
		chk(CLEAR_CHANNEL, 1'b1);
		chk(CLEAR_CHANNEL_IRQ_FLAG, 1'b1);
		pulse(5);
		// Channel still clear, so the set wins over the clear
		chk(CLEAR_CHANNEL_IRQ_FLAG, 1'b1);
	endtask
	// Reserved, carrier and combined criteria, then thresholds inside and beyond the hysteresis band
	task t_cca;
		for (k = 0; k < 8; k++)
		begin
			@(posedge CLK_SYS);
			{CLEAR_CHANNEL_CRITERION, CARRIER_SENSE_THRESHOLD, VALID_RECEPTION} <= CCA_TAB[k][11:1];
			wt(8);
			chk(CLEAR_CHANNEL, CCA_TAB[k][0]);
		end
	endtask
	// Busy channel refuses, clear channel starts, done returns to receive
	task t_tx;
		pulse(2);
		wt(1);
		chk(TX_ACTIVE, 1'b0);
		// Channel busy now, so the clear strobe drops the flag
		pulse(5);
		chk(CLEAR_CHANNEL_IRQ_FLAG, 1'b0);
		@(posedge CLK_SYS);
		{CLEAR_CHANNEL_CRITERION, VALID_RECEPTION} <= 3'h2;
		wt(8);
		pulse(2);
		chk(TX_ACTIVE, 1'b1);
		chk(RADIO_STATE, 5'h08);
		repeat (40) if (RADIO_STATE !== 5'h10) wt(1);
		chk(RADIO_STATE, 5'h10);
		pulse(4);
		repeat (40) if (RADIO_STATE !== 5'h04) wt(1);
		chk(RADIO_STATE, 5'h04);
		chk(TX_ACTIVE, 1'b0);
	endtask
	// Delimiter, eight symbols, frame end, then the trailer
	task t_frame;
		pulse(6);
		wt(40);
		pulse(7);
		repeat (20) if (APPEND_VALID !== 1'b1) @(negedge CLK_SYS);
		chk(APPEND_VALID, 1'b1);
		chk(APPEND_CORR_CRC, 8'hd0);
		chk({4'h0, APPEND_STRENGTH}, 12'h0d8);
	endtask
	// Radio off from receive and from transmit calibration, direct transmit enable from idle calibrates first
	task t_off;
		pulse(3);
		chk(RADIO_STATE, 5'h01);
		pulse(1);
		chk(RADIO_STATE, 5'h08);
		chk(TX_ACTIVE, 1'b1);
		wt(1);
		chk(SYNTH_CALIBRATE, 1'b1);
		pulse(3);
		chk(RADIO_STATE, 5'h01);
		chk(TX_ACTIVE, 1'b0);
	endtask
	// ****
	// Main sequence
	// ****
	initial
	begin
		@(posedge CLK_SYS);
		#1;
		chk(RADIO_STATE, 5'h01);
		chk(PA_POWER_CODE, 8'hff);
		@(posedge CLK_SYS);
		RST_N <= 1'b1;
		t_synth_channel_word;
		t_rx;
		t_cca;
		t_tx;
		t_frame;
		t_off;
		end_of_test;
	end
endmodule
